//--- rtl/usbtc_pkg.sv
// Constants for the transceiver control and indirect register access block.
// Assumes a single 200 MHz clock domain and a byte-wide special register port.
package usbtc_pkg;
  // ---------------------------------------------------------------
  // Special register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_XCVR_CTRL  = 8'hD7;
  localparam logic [7:0] SFR_IND_ADDR   = 8'h96;
  localparam logic [7:0] SFR_IND_DATA   = 8'h97;
  // ---------------------------------------------------------------
  // Transceiver control field positions
  // ---------------------------------------------------------------
  localparam int BIT_PULLUP_EN   = 7;
  localparam int BIT_XCVR_EN     = 6;
  localparam int BIT_SPEED       = 5;
  localparam int BIT_TEST_HI     = 4;
  localparam int BIT_TEST_LO     = 3;
  localparam int BIT_DIFF_RX     = 2;
  localparam int BIT_PLUS_LVL    = 1;
  localparam int BIT_MINUS_LVL   = 0;
  localparam logic [7:0] XCVR_CTRL_RESET = 8'h00;
  localparam logic [7:0] IND_ADDR_RESET  = 8'h00;
  // ---------------------------------------------------------------
  // Internal controller map
  // ---------------------------------------------------------------
  localparam int IND_ADDR_W       = 6;
  localparam logic [5:0] REG_INDEX      = 6'h0E;
  localparam logic [5:0] INDEXED_FIRST  = 6'h10;
  localparam logic [5:0] INDEXED_LAST   = 6'h1F;
  localparam int NUM_EP           = 4;
  localparam int EP_W             = 2;
  // ---------------------------------------------------------------
  // Test modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    USBTC_TEST_NORMAL = 2'h0,
    USBTC_TEST_DIFF1  = 2'h1,
    USBTC_TEST_DIFF0  = 2'h2,
    USBTC_TEST_SE0    = 2'h3
  } usbtc_test_e;
endpackage : usbtc_pkg

//--- rtl/usbtc_regs_if.sv
// Carrier between the top level and the indirect register file.
// Assumes both ends share clk_in.
`timescale 1ns/1ps
interface usbtc_regs_if;
  logic       wr;
  logic       rd;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output wr, rd, addr, wdata, input rdata);
  modport regs (input wr, rd, addr, wdata, output rdata);
endinterface : usbtc_regs_if

//--- rtl/usbtc_ind_regs.sv
// Internal controller register file reached through the address/data pair.
// Assumes the usb clock is running during every access (caller's duty).
`timescale 1ns/1ps
module usbtc_ind_regs #(
  parameter int NUM_EP = usbtc_pkg::NUM_EP
) (
  // Clock and control
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Access port
  usbtc_regs_if.regs      bus
);
  // Flat registers plus one bank of indexed registers per endpoint
  logic [7:0] flat      [64];
  logic [7:0] ep_bank   [NUM_EP][16];
  logic [usbtc_pkg::EP_W-1:0] ep_sel;
  logic       in_indexed;

  function automatic logic is_indexed(input logic [5:0] a);
    return (a >= usbtc_pkg::INDEXED_FIRST) && (a <= usbtc_pkg::INDEXED_LAST);
  endfunction : is_indexed

  assign in_indexed = is_indexed(bus.addr);
  assign ep_sel     = flat[usbtc_pkg::REG_INDEX][usbtc_pkg::EP_W-1:0];

  // Indexed addresses land in the bank of the selected endpoint [R09]
  // Read data is only presented while the data register is being read
  always_comb begin
    bus.rdata = 8'h00;
    if (bus.rd) begin
      if (in_indexed) begin
        bus.rdata = ep_bank[ep_sel][bus.addr[3:0]]; // [R07] [R09]
      end else begin
        bus.rdata = flat[bus.addr]; // [R07]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 64; i++) flat[i] <= 8'h00;
      for (int e = 0; e < NUM_EP; e++)
        for (int j = 0; j < 16; j++) ep_bank[e][j] <= 8'h00;
    end else if (ce_in && bus.wr) begin
      if (in_indexed) begin
        ep_bank[ep_sel][bus.addr[3:0]] <= bus.wdata; // [R09]
      end else begin
        flat[bus.addr] <= bus.wdata; // [R07]
      end
    end
  end

  a_index_steers_bank: assert property (@(posedge clk_in) disable iff (rst_in) // [R09]
    ce_in && bus.wr && in_indexed |=> ep_bank[$past(ep_sel)][$past(bus.addr[3:0])]
      == $past(bus.wdata))
    else $error("indexed write missed selected endpoint bank");
  a_flat_write_lands: assert property (@(posedge clk_in) disable iff (rst_in) // [R07]
    ce_in && bus.wr && !in_indexed |=> flat[$past(bus.addr)] == $past(bus.wdata))
    else $error("data write missed addressed register");
endmodule : usbtc_ind_regs

//--- rtl/usbtc_xcvr_ctrl.sv
// Transceiver control, line forcing, status and indirect access pair.
// Assumes a byte-wide special register port synchronous to clk_in and
// that the analog pad logic acts on the drive and pull-up outputs.
//
// Overview of operation
// R01: Enable bit puts transceiver in normal operation
// R02: Speed bit zero selects low speed
// R03: Low speed pull-up goes on minus line
// R04: Speed bit one selects full speed
// R05: Full speed pull-up goes on plus line
// R06: Internal registers reached only through address/data pair
// R07: Data accesses target register held in address
// R08: Software writes endpoint select before endpoint access
// R09: Endpoint select steers indexed register addresses
// R10: Software keeps usb clock running during access
// R11: Pull-up applied only while bus supply present
// R12: Test field forces J, K or SE0
// R13: Status shows differential receive and line levels
`timescale 1ns/1ps
module usbtc_xcvr_ctrl (
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Special register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // Line sense and supply detect
  input  wire logic       plus_line_in,
  input  wire logic       minus_line_in,
  input  wire logic       vbus_present_in,
  // Line drive, enables low while driving
  output logic            plus_line_out,
  output logic            plus_line_oe_n_out,
  output logic            minus_line_out,
  output logic            minus_line_oe_n_out,
  // Transceiver configuration to the analog side
  output logic            xcvr_active_out,
  output logic            full_speed_out,
  output logic            plus_pullup_out,
  output logic            minus_pullup_out
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [5:0] ind_addr;
  logic [5:0] next_ind_addr;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [2:0] line_st;
  logic [2:0] next_line_st;

  logic       pull_en;
  logic       xcvr_en;
  logic       speed;
  usbtc_pkg::usbtc_test_e test_mode;

  usbtc_regs_if rif ();

  usbtc_ind_regs #(
    .NUM_EP (usbtc_pkg::NUM_EP)
  ) u_regs (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .bus    (rif)
  );

  assign pull_en   = ctrl[usbtc_pkg::BIT_PULLUP_EN];
  assign xcvr_en   = ctrl[usbtc_pkg::BIT_XCVR_EN];
  assign speed     = ctrl[usbtc_pkg::BIT_SPEED];
  assign test_mode = usbtc_pkg::usbtc_test_e'(
                       ctrl[usbtc_pkg::BIT_TEST_HI:usbtc_pkg::BIT_TEST_LO]);

  // ---------------------------------------------------------------
  // Indirect access: only the data register reaches the internals
  // ---------------------------------------------------------------
  always_comb begin
    rif.addr  = ind_addr; // [R06] [R07]
    rif.wdata = sfr_wdata_in;
    rif.wr    = sfr_wr_in && (sfr_addr_in == usbtc_pkg::SFR_IND_DATA); // [R06]
    rif.rd    = sfr_rd_in && (sfr_addr_in == usbtc_pkg::SFR_IND_DATA);
  end

  // ---------------------------------------------------------------
  // Register writes and read data
  // ---------------------------------------------------------------
  always_comb begin
    next_ctrl     = ctrl;
    next_ind_addr = ind_addr;
    next_rdata    = rdata;
    if (sfr_wr_in && sfr_addr_in == usbtc_pkg::SFR_XCVR_CTRL) begin
      // Status bits are read-only and stay clear in storage
      next_ctrl = {sfr_wdata_in[7:3], 3'h0};
    end
    if (sfr_wr_in && sfr_addr_in == usbtc_pkg::SFR_IND_ADDR) begin
      next_ind_addr = sfr_wdata_in[usbtc_pkg::IND_ADDR_W-1:0];
    end
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        usbtc_pkg::SFR_XCVR_CTRL: next_rdata = {ctrl[7:3], line_st}; // [R13]
        usbtc_pkg::SFR_IND_ADDR:  next_rdata = {2'h0, ind_addr};
        usbtc_pkg::SFR_IND_DATA:  next_rdata = rif.rdata; // [R07]
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  // Line status sampled each cycle with ce_in high; receive value held at 0 when disabled
  always_comb begin
    next_line_st = {xcvr_en && plus_line_in && !minus_line_in, // [R13]
                    plus_line_in, minus_line_in};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl     <= usbtc_pkg::XCVR_CTRL_RESET;
      ind_addr <= usbtc_pkg::IND_ADDR_RESET[5:0];
      rdata    <= 8'h00;
      line_st  <= 3'h0;
    end else if (ce_in) begin
      ctrl     <= next_ctrl;
      ind_addr <= next_ind_addr;
      rdata    <= next_rdata;
      line_st  <= next_line_st;
    end
  end

  assign sfr_rdata_out = rdata;

  // ---------------------------------------------------------------
  // Transceiver configuration and pull-up routing
  // ---------------------------------------------------------------
  always_comb begin
    xcvr_active_out  = xcvr_en; // [R01]
    full_speed_out   = speed; // [R02] [R04]
    // Pull-up needs bus supply regardless of the enable bit
    plus_pullup_out  = pull_en && vbus_present_in && speed; // [R05] [R11]
    minus_pullup_out = pull_en && vbus_present_in && !speed; // [R03] [R11]
  end

  // ---------------------------------------------------------------
  // Test line forcing
  // ---------------------------------------------------------------
  always_comb begin
    plus_line_out       = 1'b0;
    minus_line_out      = 1'b0;
    plus_line_oe_n_out  = 1'b0;
    minus_line_oe_n_out = 1'b0;
    unique case (test_mode)
      usbtc_pkg::USBTC_TEST_NORMAL: begin
        // Serial engine owns the lines; this block leaves them released
        plus_line_oe_n_out  = 1'b1; // [R12]
        minus_line_oe_n_out = 1'b1;
      end
      usbtc_pkg::USBTC_TEST_DIFF1: begin
        plus_line_out = 1'b1; // [R12]
      end
      usbtc_pkg::USBTC_TEST_DIFF0: begin
        minus_line_out = 1'b1; // [R12]
      end
      usbtc_pkg::USBTC_TEST_SE0: begin
        plus_line_out = 1'b0; // [R12]
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Pull-up routing follows speed only while the bus supply is present
  a_pullup_needs_vbus: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    !vbus_present_in |-> !plus_pullup_out && !minus_pullup_out)
    else $error("pull-up applied without bus supply");
  a_pullup_low_speed: assert property (@(posedge clk_in) disable iff (rst_in) // [R02] [R03]
    pull_en && vbus_present_in && !full_speed_out |-> minus_pullup_out && !plus_pullup_out)
    else $error("low speed pull-up not on minus line");
  a_pullup_full_speed: assert property (@(posedge clk_in) disable iff (rst_in) // [R04] [R05]
    pull_en && vbus_present_in && full_speed_out |-> plus_pullup_out && !minus_pullup_out)
    else $error("full speed pull-up not on plus line");
  a_enable_follows_write: assert property (@(posedge clk_in) disable iff (rst_in) // [R01]
    ce_in && sfr_wr_in && sfr_addr_in == usbtc_pkg::SFR_XCVR_CTRL
      |=> xcvr_active_out == $past(sfr_wdata_in[usbtc_pkg::BIT_XCVR_EN]))
    else $error("transceiver enable did not follow write");
  a_speed_follows_write: assert property (@(posedge clk_in) disable iff (rst_in) // [R02] [R04]
    ce_in && sfr_wr_in && sfr_addr_in == usbtc_pkg::SFR_XCVR_CTRL
      |=> full_speed_out == $past(sfr_wdata_in[usbtc_pkg::BIT_SPEED]))
    else $error("speed select did not follow write");
  // Line forcing: a driven line always has its enable low
  a_test_normal: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    test_mode == usbtc_pkg::USBTC_TEST_NORMAL |-> plus_line_oe_n_out && minus_line_oe_n_out)
    else $error("lines not released in normal mode");
  a_test_diff1: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    test_mode == usbtc_pkg::USBTC_TEST_DIFF1 |-> plus_line_out && !minus_line_out
      && !plus_line_oe_n_out && !minus_line_oe_n_out)
    else $error("differential one not forced");
  a_test_diff0: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    test_mode == usbtc_pkg::USBTC_TEST_DIFF0 |-> !plus_line_out && minus_line_out
      && !plus_line_oe_n_out && !minus_line_oe_n_out)
    else $error("differential zero not forced");
  a_test_se0: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    test_mode == usbtc_pkg::USBTC_TEST_SE0 |-> !plus_line_out && !minus_line_out
      && !plus_line_oe_n_out && !minus_line_oe_n_out)
    else $error("single-ended zero not forced");
  // Status reads: levels lag the pins by the one status flop
  a_status_levels: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    ce_in && $past(ce_in) && sfr_rd_in && sfr_addr_in == usbtc_pkg::SFR_XCVR_CTRL
      |=> sfr_rdata_out[1:0] == $past({plus_line_in, minus_line_in}, 2))
    else $error("line level status wrong");
  a_status_diff_gated: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    ce_in && $past(ce_in) && !$past(xcvr_en) && sfr_rd_in
      && sfr_addr_in == usbtc_pkg::SFR_XCVR_CTRL |=> !sfr_rdata_out[usbtc_pkg::BIT_DIFF_RX])
    else $error("differential receive shown while disabled");
  a_data_read_path: assert property (@(posedge clk_in) disable iff (rst_in) // [R07]
    ce_in && rif.rd |=> sfr_rdata_out == $past(rif.rdata))
    else $error("data register read not taken from addressed register");
endmodule : usbtc_xcvr_ctrl

//--- sim/usbtc_host_model.sv
// Far side of the data lines: host pull-downs plus an optional host line driver.
// Assumes the device drives a line only while its active low enable is low.
`timescale 1ns/1ps
module usbtc_host_model (
  // Device drive and pull-ups
  input  wire logic dev_plus_in,
  input  wire logic dev_plus_oe_n_in,
  input  wire logic dev_minus_in,
  input  wire logic dev_minus_oe_n_in,
  input  wire logic plus_pullup_in,
  input  wire logic minus_pullup_in,
  // Host driver
  input  wire logic host_drive_in,
  input  wire logic host_plus_in,
  input  wire logic host_minus_in,
  // Resolved wire levels
  output logic      plus_line_out,
  output logic      minus_line_out
);
  // A released line takes the host driver while it drives, else falls to the host pull-down unless the device pull-up wins
  assign plus_line_out  = !dev_plus_oe_n_in ? dev_plus_in :
                          host_drive_in ? host_plus_in : plus_pullup_in;
  assign minus_line_out = !dev_minus_oe_n_in ? dev_minus_in :
                          host_drive_in ? host_minus_in : minus_pullup_in;
endmodule : usbtc_host_model

//--- sim/usb_transceiver_ctrl_regaccess_tb.sv
// Self-checking bench for the transceiver control and indirect access block.
// Assumes the host model resolves the data lines back into the pin inputs.
`timescale 1ns/1ps
module usb_transceiver_ctrl_regaccess_tb;
  localparam logic [7:0] CTRL = usbtc_pkg::SFR_XCVR_CTRL;
  localparam logic [7:0] IADR = usbtc_pkg::SFR_IND_ADDR;
  localparam logic [7:0] IDAT = usbtc_pkg::SFR_IND_DATA;
  logic       clk = 0, rst, ce, wr, rd, vbus, hdrv, hp, hm;
  logic [7:0] addr, wdata, rdata;
  logic       pl, ml, po, pon, mo, mon, xa, fs, pp, mp;
  int         n_fail = 0, tests_run = 0, cyc = 0;
  always #2.5 clk = ~clk;
  usbtc_xcvr_ctrl dut_u (.clk_in(clk), .rst_in(rst), .ce_in(ce), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .plus_line_in(pl), .minus_line_in(ml), .vbus_present_in(vbus),
    .plus_line_out(po), .plus_line_oe_n_out(pon), .minus_line_out(mo),
    .minus_line_oe_n_out(mon), .xcvr_active_out(xa), .full_speed_out(fs),
    .plus_pullup_out(pp), .minus_pullup_out(mp));
  usbtc_host_model host_u (.dev_plus_in(po), .dev_plus_oe_n_in(pon), .dev_minus_in(mo),
    .dev_minus_oe_n_in(mon), .plus_pullup_in(pp), .minus_pullup_in(mp),
    .host_drive_in(hdrv), .host_plus_in(hp), .host_minus_in(hm),
    .plus_line_out(pl), .minus_line_out(ml));
  task automatic test_done;
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Extra idle edge lets the one-cycle-late line status settle
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    @(posedge clk) #1 wr = 0;
    @(posedge clk) #1;
  endtask : sfr_wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1;
    @(posedge clk) #1 rd = 0;
    @(posedge clk) #1 chk(rdata, exp);
  endtask : rd_chk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    logic [1:0] m;
    rst = 1; ce = 1; wr = 0; rd = 0; addr = 0; wdata = 0; vbus = 1;
    hdrv = 0; hp = 0; hm = 0;
    repeat (6) @(posedge clk);
    #1 rst = 0;
    rd_chk(CTRL, 8'h00);
    sfr_wr(CTRL, 8'hE7);
    chk({7'h0, xa}, 8'h01);
    chk({6'h0, fs, pp}, 8'h03);
    chk({7'h0, mp}, 8'h00);
    rd_chk(CTRL, 8'hE6);
    vbus = 0;
    @(posedge clk) #1 chk({6'h0, pp, mp}, 8'h00);
    vbus = 1;
    sfr_wr(CTRL, 8'hC0);
    chk({6'h0, fs, mp}, 8'h01);
    chk({7'h0, pp}, 8'h00);
    rd_chk(CTRL, 8'hC1);
    sfr_wr(CTRL, 8'hA0);
    chk({7'h0, xa}, 8'h00);
    rd_chk(CTRL, 8'hA2);
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      sfr_wr(CTRL, {3'b011, m, 3'b000});
      chk({6'h0, pon, mon}, (m == 2'h0) ? 8'h03 : 8'h00);
      if (m != 2'h0) chk({6'h0, pl, ml}, {6'h0, m == 2'h1, m == 2'h2});
    end
    sfr_wr(CTRL, 8'h40);
    hdrv = 1; hp = 1;
    @(posedge clk) #1 rd_chk(CTRL, 8'h46);
    hp = 0; hm = 1;
    @(posedge clk) #1 rd_chk(CTRL, 8'h41);
    hdrv = 0;
    ce = 0;
    sfr_wr(CTRL, 8'hFF);
    ce = 1;
    // One edge lets the status flops, frozen with the enable, catch up
    @(posedge clk) #1 rd_chk(CTRL, 8'h40);
    sfr_wr(IADR, 8'hC5);
    rd_chk(IADR, 8'h05);
    sfr_wr(IDAT, 8'h3C);
    rd_chk(IDAT, 8'h3C);
    for (int e = 1; e < 3; e++) begin
      sfr_wr(IADR, 8'h0E);
      sfr_wr(IDAT, 8'(e));
      sfr_wr(IADR, 8'h11);
      sfr_wr(IDAT, 8'h50 + 8'(e));
    end
    for (int e = 1; e < 3; e++) begin
      sfr_wr(IADR, 8'h0E);
      sfr_wr(IDAT, 8'(e));
      sfr_wr(IADR, 8'h11);
      rd_chk(IDAT, 8'h50 + 8'(e));
    end
    sfr_wr(IADR, 8'h05);
    rd_chk(IDAT, 8'h3C);
    sfr_wr(8'h40, 8'hFF);
    rd_chk(8'h40, 8'h00);
    rd_chk(CTRL, 8'h40);
    rst = 1;
    @(posedge clk) #1 rst = 0;
    chk({4'h0, xa, pp, pon, mon}, 8'h03);
    sfr_wr(IADR, 8'h05);
    rd_chk(IDAT, 8'h00);
    test_done;
  end
endmodule : usb_transceiver_ctrl_regaccess_tb
